/* File: sso_pkg.sv */
package sso_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int          SPD_W        = 16;
  localparam int          NUM_TERM     = 3;
  localparam int          IRQ_W        = 4;
  localparam logic [13:0] ROT_LVL_MIN  = 14'h0001;
  localparam logic [13:0] ROT_LVL_MAX  = 14'h2710;
  localparam logic [13:0] ROT_LVL_DEF  = 14'h0014;
  localparam logic [9:0]  HOLD_MS_MIN  = 10'h014;
  localparam logic [9:0]  HOLD_MS_MAX  = 10'h3E8;
  localparam logic [9:0]  HOLD_MS_DEF  = 10'h014;
  localparam logic [6:0]  MATCH_MAX    = 7'h64;
  localparam logic [6:0]  MATCH_DEF    = 7'h0A;
  localparam logic [15:0] SEL_DEF      = 16'h0000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_ROT_LVL   = 6'h00;
  localparam logic [5:0] OFS_HOLD      = 6'h04;
  localparam logic [5:0] OFS_SEL_ONE   = 6'h08;
  localparam logic [5:0] OFS_SEL_TWO   = 6'h0C;
  localparam logic [5:0] OFS_SEL_THREE = 6'h10;
  localparam logic [5:0] OFS_CFG       = 6'h14;
  localparam logic [5:0] OFS_MATCH     = 6'h18;
  localparam logic [5:0] OFS_STATUS    = 6'h1C;
  localparam logic [5:0] OFS_IRQ_ST    = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK  = 6'h24;

  // ----------------------------------------------------------------
  // Field positions and default terminal pairs
  // ----------------------------------------------------------------
  localparam int         SEL_MATCH_LSB = 0;
  localparam int         SEL_RUN_LSB   = 4;
  localparam int         SEL_RDY_LSB   = 8;
  localparam int         SEL_WARN_LSB  = 12;
  localparam int         SEL_POSITION_OUT_A_LSB  = 0;
  localparam logic [3:0] PAIR_NONE     = 4'h0;
  localparam logic [3:0] PAIR_MATCH_DEF = 4'h1;
  localparam logic [3:0] PAIR_RUN_DEF  = 4'h2;
  localparam logic [3:0] PAIR_RDY_DEF  = 4'h3;
  localparam int         CFG_WCODE_BIT = 0;
  localparam int         CFG_ABS_BIT   = 1;
  localparam int         IRQ_RUN       = 0;
  localparam int         IRQ_TRIP      = 1;
  localparam int         IRQ_WARN      = 2;
  localparam int         IRQ_ALARM     = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 40;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int PRE_W      = 20;

  typedef enum logic [1:0] {PWR_ON, PWR_HOLD, PWR_TRIP} sso_pwr_e;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [5:0]        address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } sso_avs_req_s;

  typedef struct packed {
    logic signed [SPD_W-1:0] motor_speed;
    logic signed [SPD_W-1:0] speed_ref;
    logic                    servo_alarm;
    logic [2:0]              alarm_code;
    logic                    main_power_on;
    logic                    control_power_ok;
    logic                    undervolt_alarm;
    logic                    sensor_on_input;
    logic                    abs_data_sent;
    logic                    overload_warn;
    logic                    regen_warn;
    logic                    position_position_out_a;
  } sso_drv_s;

endpackage : sso_pkg

/* File: sso_status_outputs.sv */
`timescale 1ns/10ps

module sso_status_outputs #(
  parameter int CYC_PER_MS = sso_pkg::CYC_PER_MS
) (
  input  wire logic                        mclk,                 // Control clock, 25 MHz.
  input  wire logic                        rst_n,                // Synchronous reset, active low.
  input  wire sso_pkg::sso_avs_req_s       avs_req,              // Avalon-MM request.
  output logic [31:0]                      avs_readdata,         // Avalon-MM read data.
  output logic                             avs_waitrequest,      // Avalon-MM wait request.
  input  wire sso_pkg::sso_drv_s           drv,                  // Drive status inputs.
  output logic [sso_pkg::NUM_TERM-1:0]     term_n,               // Terminal pairs, low means closed.
  output logic                             code_line_one_n,      // Code line one, low means on.
  output logic                             code_line_two_n,      // Code line two, low means on.
  output logic                             code_line_three_n,    // Code line three, low means on.
  output logic                             running_indicator,    // Status display running lamp.
  output logic                             speed_detect_monitor, // Monitor view running flag.
  output logic                             motor_on,             // Motor energised.
  output logic                             irq                   // Level interrupt.
);
  import sso_pkg::*;

  typedef struct packed {
    logic [13:0]         rot_lvl;
    logic [9:0]          hold_ms;
    logic [15:0]         sel_one;
    logic [15:0]         sel_two;
    logic [15:0]         sel_three;
    logic [1:0]          cfg;
    logic [6:0]          match_w;
    logic [IRQ_W-1:0]    irq_st;
    logic [IRQ_W-1:0]    irq_mask;
    logic                irq;
    logic                bus_wait;
    logic [31:0]         rdata;
    sso_pwr_e            pwr;
    logic [PRE_W-1:0]    pre;
    logic [9:0]          ms_cnt;
    logic                running;
    logic                ready;
    logic                warning;
    logic                match;
    logic                motor_on;
    logic [NUM_TERM-1:0] term_n;
    logic [2:0]          code_n;
  } sso_st_s;

  sso_st_s st_r;
  sso_st_s st_nxt;

  logic [SPD_W:0]      spd_abs;
  logic [SPD_W:0]      err_abs;
  logic signed [SPD_W:0] err;
  logic                req;
  logic                alarm_ev;
  logic [31:0]         status_word;
  logic [31:0]         wmask;
  logic [31:0]         wval;
  logic [2:0]          code;
  logic [NUM_TERM-1:0] term_act;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pair_hit(input logic [3:0] field, input logic [3:0] dflt, input int idx);
    logic [3:0] pick;
    pick = (field == PAIR_NONE) ? dflt : field;
    return pick == 4'(idx + 1);
  endfunction : pair_hit

  assign req = avs_req.read | avs_req.write;

  // ----------------------------------------------------------------
  // Terminal allocation
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++)
    begin : g_term
      assign term_act[gi] =
        (st_nxt.running && pair_hit(st_r.sel_one[SEL_RUN_LSB +: 4], PAIR_RUN_DEF, gi)) |
        (st_nxt.ready   && pair_hit(st_r.sel_one[SEL_RDY_LSB +: 4], PAIR_RDY_DEF, gi)) |
        (st_nxt.match   && pair_hit(st_r.sel_one[SEL_MATCH_LSB +: 4], PAIR_MATCH_DEF, gi)) |
        (st_nxt.warning && pair_hit(st_r.sel_two[SEL_WARN_LSB +: 4], PAIR_NONE, gi)) |
        (drv.position_position_out_a && pair_hit(st_r.sel_three[SEL_POSITION_OUT_A_LSB +: 4], PAIR_NONE, gi));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    spd_abs = drv.motor_speed[SPD_W-1] ? (SPD_W+1)'(-drv.motor_speed) : (SPD_W+1)'(drv.motor_speed);
    err = (SPD_W+1)'(drv.speed_ref) - (SPD_W+1)'(drv.motor_speed);
    err_abs = err[SPD_W] ? (SPD_W+1)'(-err) : (SPD_W+1)'(err);
    wmask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
             {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    status_word = 32'h0000_0000;
    wval = 32'h0000_0000;
    code = 3'h0;
    alarm_ev = 1'b0;

    st_nxt.running = spd_abs > (SPD_W+1)'(st_r.rot_lvl);
    st_nxt.ready = !drv.servo_alarm && drv.main_power_on &&
                   (!st_r.cfg[CFG_ABS_BIT] || (drv.sensor_on_input && drv.abs_data_sent));
    st_nxt.warning = drv.overload_warn | drv.regen_warn;
    st_nxt.match = err_abs < (SPD_W+1)'(st_r.match_w);

    unique case (st_r.pwr)
      PWR_ON:
      begin
        st_nxt.pre = '0;
        st_nxt.ms_cnt = 10'h000;
        if (!drv.main_power_on)
          st_nxt.pwr = PWR_HOLD;
      end
      PWR_HOLD:
      begin
        if (drv.main_power_on)
          st_nxt.pwr = PWR_ON;
        else if (st_r.ms_cnt >= st_r.hold_ms)
          st_nxt.pwr = PWR_TRIP;
        else if (st_r.pre == PRE_W'(CYC_PER_MS - 1))
        begin
          st_nxt.pre = '0;
          st_nxt.ms_cnt = st_r.ms_cnt + 10'h001;
        end
        else
          st_nxt.pre = st_r.pre + PRE_W'(1);
      end
      PWR_TRIP:
      begin
        if (drv.main_power_on)
          st_nxt.pwr = PWR_ON;
      end
    endcase
    st_nxt.motor_on = drv.control_power_ok && !drv.undervolt_alarm && st_nxt.pwr != PWR_TRIP;

    if (drv.servo_alarm)
      code = drv.alarm_code;
    else if (st_r.cfg[CFG_WCODE_BIT] && drv.overload_warn)
      code = 3'h1;
    else if (st_r.cfg[CFG_WCODE_BIT] && drv.regen_warn)
      code = 3'h2;
    st_nxt.code_n = ~code;
    st_nxt.term_n = ~term_act;

    status_word[0] = st_r.running;
    status_word[1] = st_r.ready;
    status_word[2] = st_r.warning;
    status_word[3] = st_r.motor_on;
    status_word[4] = st_r.match;
    status_word[5] = drv.position_position_out_a;
    status_word[10:8] = st_r.term_n;
    status_word[14:12] = st_r.code_n;
    status_word[17:16] = st_r.pwr;

    // Avalon slave: first cycle latches read data and drops waitrequest together.
    if (req && st_r.bus_wait)
    begin
      st_nxt.bus_wait = 1'b0;
      unique case (avs_req.address)
        OFS_ROT_LVL:   st_nxt.rdata = 32'(st_r.rot_lvl);
        OFS_HOLD:      st_nxt.rdata = 32'(st_r.hold_ms);
        OFS_SEL_ONE:   st_nxt.rdata = 32'(st_r.sel_one);
        OFS_SEL_TWO:   st_nxt.rdata = 32'(st_r.sel_two);
        OFS_SEL_THREE: st_nxt.rdata = 32'(st_r.sel_three);
        OFS_CFG:       st_nxt.rdata = 32'(st_r.cfg);
        OFS_MATCH:     st_nxt.rdata = 32'(st_r.match_w);
        OFS_STATUS:    st_nxt.rdata = status_word;
        OFS_IRQ_ST:    st_nxt.rdata = 32'(st_r.irq_st);
        OFS_IRQ_MASK:  st_nxt.rdata = 32'(st_r.irq_mask);
        default:       st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    else if (req)
    begin
      st_nxt.bus_wait = 1'b1;
    end

    if (avs_req.write && !st_r.bus_wait)
    begin
      unique case (avs_req.address)
        OFS_ROT_LVL:
        begin
          wval = (32'(st_r.rot_lvl) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.rot_lvl = (wval < 32'(ROT_LVL_MIN)) ? ROT_LVL_MIN :
                           (wval > 32'(ROT_LVL_MAX)) ? ROT_LVL_MAX : wval[13:0];
        end
        OFS_HOLD:
        begin
          wval = (32'(st_r.hold_ms) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.hold_ms = (wval < 32'(HOLD_MS_MIN)) ? HOLD_MS_MIN :
                           (wval > 32'(HOLD_MS_MAX)) ? HOLD_MS_MAX : wval[9:0];
        end
        OFS_SEL_ONE:
        begin
          wval = (32'(st_r.sel_one) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.sel_one = wval[15:0];
        end
        OFS_SEL_TWO:
        begin
          wval = (32'(st_r.sel_two) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.sel_two = wval[15:0];
        end
        OFS_SEL_THREE:
        begin
          wval = (32'(st_r.sel_three) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.sel_three = wval[15:0];
        end
        OFS_CFG:
        begin
          wval = (32'(st_r.cfg) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.cfg = wval[1:0];
        end
        OFS_MATCH:
        begin
          wval = (32'(st_r.match_w) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.match_w = (wval > 32'(MATCH_MAX)) ? MATCH_MAX : wval[6:0];
        end
        OFS_IRQ_ST:
        begin
          wval = avs_req.writedata & wmask;
          st_nxt.irq_st = st_r.irq_st & ~wval[IRQ_W-1:0];
        end
        OFS_IRQ_MASK:
        begin
          wval = (32'(st_r.irq_mask) & ~wmask) | (avs_req.writedata & wmask);
          st_nxt.irq_mask = wval[IRQ_W-1:0];
        end
        default:
        begin
          wval = 32'h0000_0000;
        end
      endcase
    end

    // Events set sticky bits after any clear, so a set wins.
    alarm_ev = drv.servo_alarm;
    st_nxt.irq_st[IRQ_RUN]   = st_nxt.irq_st[IRQ_RUN]   | (st_nxt.running && !st_r.running);
    st_nxt.irq_st[IRQ_TRIP]  = st_nxt.irq_st[IRQ_TRIP]  | (st_nxt.pwr == PWR_TRIP && st_r.pwr != PWR_TRIP);
    st_nxt.irq_st[IRQ_WARN]  = st_nxt.irq_st[IRQ_WARN]  | (st_nxt.warning && !st_r.warning);
    st_nxt.irq_st[IRQ_ALARM] = st_nxt.irq_st[IRQ_ALARM] | alarm_ev;
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r           <= '0;
      st_r.rot_lvl   <= ROT_LVL_DEF;
      st_r.hold_ms   <= HOLD_MS_DEF;
      st_r.sel_one   <= SEL_DEF;
      st_r.sel_two   <= SEL_DEF;
      st_r.sel_three <= SEL_DEF;
      st_r.match_w   <= MATCH_DEF;
      st_r.bus_wait  <= 1'b1;
      st_r.pwr       <= PWR_ON;
      st_r.term_n    <= '1;
      st_r.code_n    <= '1;
    end
    else
      st_r <= st_nxt;
  end

  assign avs_readdata         = st_r.rdata;
  assign avs_waitrequest      = st_r.bus_wait;
  assign term_n               = st_r.term_n;
  assign code_line_one_n      = st_r.code_n[0];
  assign code_line_two_n      = st_r.code_n[1];
  assign code_line_three_n    = st_r.code_n[2];
  assign running_indicator    = st_r.running;
  assign speed_detect_monitor = st_r.running;
  assign motor_on             = st_r.motor_on;
  assign irq                  = st_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_running_level: assert property ($past(spd_abs) > (SPD_W+1)'($past(st_r.rot_lvl)) |-> running_indicator)
    else $error("running flag missing above level");
  a_run_default_pair: assert property (running_indicator && st_r.sel_one == SEL_DEF |-> !term_n[1])
    else $error("running not on default pair");
  a_ready_alarm: assert property ($past(drv.servo_alarm) |-> !st_r.ready)
    else $error("ready while alarm active");
  a_warn_code: assert property (st_r.cfg[CFG_WCODE_BIT] && !drv.servo_alarm && drv.overload_warn
                                |=> !code_line_one_n && code_line_two_n && code_line_three_n)
    else $error("overload code wrong");
  a_code_mode_zero: assert property (!st_r.cfg[CFG_WCODE_BIT] && !drv.servo_alarm
                                     |=> code_line_one_n && code_line_two_n && code_line_three_n)
    else $error("warning code in alarm-only mode");
  a_short_drop: assert property (st_r.pwr == PWR_ON && !drv.main_power_on ##1 drv.main_power_on
                                 |=> st_r.pwr == PWR_ON)
    else $error("short dropout not ignored");
  a_trip_off: assert property (st_r.pwr == PWR_TRIP |-> !motor_on)
    else $error("motor on after trip");
  a_ctrl_loss: assert property (!drv.control_power_ok |=> !motor_on)
    else $error("motor on without control power");
  a_hold_range: assert property (st_r.hold_ms >= HOLD_MS_MIN && st_r.hold_ms <= HOLD_MS_MAX)
    else $error("hold time out of range");
  a_level_range: assert property (st_r.rot_lvl >= ROT_LVL_MIN && st_r.rot_lvl <= ROT_LVL_MAX)
    else $error("level out of range");
  a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not released");

  c_trip: cover property (st_r.pwr == PWR_HOLD ##1 st_r.pwr == PWR_TRIP);
  c_run_rise: cover property (!running_indicator ##1 running_indicator);
  c_regen_code: cover property (!code_line_two_n && code_line_one_n);
  c_irq: cover property (irq);

endmodule : sso_status_outputs

/* File: sso_host_model.sv */
`timescale 1ns/10ps
module sso_host_model #(
  parameter int SCAN = 3
) (
  input  wire logic       mclk,   // Control clock.
  input  wire logic       rst_n,  // Reset, active low.
  input  wire logic [2:0] term_n, // Interlock terminals from the drive.
  output logic      [2:0] seen_n  // Levels the host accepts.
);
  logic [2:0] last_r;
  int         cnt_r;
  always @(posedge mclk)
  begin
    if (!rst_n || term_n !== last_r)
    begin
      cnt_r  <= 0;
      last_r <= term_n;
      if (!rst_n)
        seen_n <= 3'h7;
    end
    else if (cnt_r < SCAN)
      cnt_r <= cnt_r + 1;
    else
      seen_n <= last_r;
  end
endmodule : sso_host_model

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import sso_pkg::*;
  logic mclk = 0, rst_n = 0, avs_waitrequest, irq, motor_on, run_ind, spd_mon, c1_n, c2_n, c3_n;
  logic [31:0] avs_readdata, rdv;
  logic [2:0]  term_n, seen_n;
  sso_avs_req_s avs_req = '0;
  sso_drv_s     drv = '0;
  int err_count = 0, num_checks = 0, wd = 0;
  sso_status_outputs #(.CYC_PER_MS(4)) u_dut (.mclk(mclk), .rst_n(rst_n), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drv(drv), .term_n(term_n),
    .code_line_one_n(c1_n), .code_line_two_n(c2_n), .code_line_three_n(c3_n),
    .running_indicator(run_ind), .speed_detect_monitor(spd_mon), .motor_on(motor_on), .irq(irq));
  sso_host_model u_host (.mclk(mclk), .rst_n(rst_n), .term_n(term_n), .seen_n(seen_n));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    wd <= wd + 1;
    if (wd == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
    avs_req <= '0;
    @(posedge mclk);
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d, rdv);
  endtask : wr
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, rdv);
    chk(nm, exp, rdv);
  endtask : rchk
  task automatic t_reset_and_regs();
    chk("term_n reset", 32'h7, term_n);
    chk("codes reset", 32'h7, {c3_n, c2_n, c1_n});
    rchk("rot level def", OFS_ROT_LVL, 32'h14);
    rchk("hold def", OFS_HOLD, 32'h14);
    rchk("sel two def", OFS_SEL_TWO, 32'h0);
    rchk("sel three def", OFS_SEL_THREE, 32'h0);
    rchk("cfg def", OFS_CFG, 32'h0);
    rchk("unmapped", 6'h28, 32'h0);
    wr(OFS_ROT_LVL, 32'h0);
    rchk("rot level low clamp", OFS_ROT_LVL, 32'h1);
    wr(OFS_ROT_LVL, 32'h4E20);
    rchk("rot level high clamp", OFS_ROT_LVL, 32'h2710);
    wr(OFS_HOLD, 32'h5);
    rchk("hold low clamp", OFS_HOLD, 32'h14);
    wr(OFS_HOLD, 32'h7D0);
    rchk("hold high clamp", OFS_HOLD, 32'h3E8);
    wr(OFS_HOLD, 32'h14);
  endtask : t_reset_and_regs
  task automatic t_running();
    wr(OFS_ROT_LVL, 32'h64);
    drv.speed_ref <= 16'sh1000;
    drv.motor_speed <= 16'sh0065;
    cyc(3);
    chk("run terminal", 32'h0, term_n[1]);
    chk("run indicator", 32'h1, {run_ind, spd_mon} == 2'b11);
    cyc(5);
    chk("host view run", 32'h0, seen_n[1]);
    drv.motor_speed <= 16'sh0064;
    cyc(3);
    chk("run at level", 32'h1, term_n[1]);
    chk("monitor at level", 32'h0, spd_mon);
    drv.motor_speed <= 16'sh0000;
    wr(OFS_ROT_LVL, 32'h14);
  endtask : t_running
  task automatic t_ready();
    cyc(3);
    chk("ready", 32'h0, term_n[2]);
    drv.servo_alarm <= 1'b1;
    cyc(3);
    chk("ready alarm", 32'h1, term_n[2]);
    drv.servo_alarm <= 1'b0;
    wr(OFS_CFG, 32'h2);
    cyc(3);
    chk("ready abs wait", 32'h1, term_n[2]);
    drv.sensor_on_input <= 1'b1;
    drv.abs_data_sent <= 1'b1;
    cyc(3);
    chk("ready abs", 32'h0, term_n[2]);
    wr(OFS_CFG, 32'h0);
  endtask : t_ready
  task automatic t_warn_alloc();
    drv.overload_warn <= 1'b1;
    cyc(3);
    chk("warn unallocated", 32'h3, term_n[1:0]);
    for (int f = 1; f <= 3; f++)
    begin
      wr(OFS_SEL_TWO, 32'(f) << 12);
      cyc(2);
      chk("warn pair", 32'h0, term_n[f-1]);
    end
    wr(OFS_SEL_TWO, 32'h1000);
    drv.overload_warn <= 1'b0;
    cyc(3);
    chk("warn cleared", 32'h1, term_n[0]);
    drv.speed_ref <= 16'sh0000;
    drv.motor_speed <= 16'sh0000;
    cyc(3);
    chk("shared pair or", 32'h0, term_n[0]);
    drv.speed_ref <= 16'sh1000;
    wr(OFS_SEL_TWO, 32'h0);
    drv.position_position_out_a <= 1'b1;
    cyc(3);
    chk("position_out_a unallocated", 32'h3, term_n[1:0]);
    wr(OFS_SEL_THREE, 32'h2);
    cyc(2);
    chk("position_out_a allocated", 32'h0, term_n[1]);
    wr(OFS_SEL_THREE, 32'h0);
    drv.position_position_out_a <= 1'b0;
  endtask : t_warn_alloc
  task automatic t_codes();
    drv.overload_warn <= 1'b1;
    cyc(3);
    chk("codes mode0", 32'h7, {c3_n, c2_n, c1_n});
    wr(OFS_CFG, 32'h1);
    cyc(2);
    chk("overload code", 32'h6, {c3_n, c2_n, c1_n});
    drv.overload_warn <= 1'b0;
    drv.regen_warn <= 1'b1;
    cyc(3);
    chk("regen code", 32'h5, {c3_n, c2_n, c1_n});
    drv.servo_alarm <= 1'b1;
    drv.alarm_code <= 3'h5;
    cyc(3);
    chk("alarm wins", 32'h2, {c3_n, c2_n, c1_n});
    drv.servo_alarm <= 1'b0;
    drv.alarm_code <= 3'h0;
    drv.regen_warn <= 1'b0;
    wr(OFS_CFG, 32'h0);
  endtask : t_codes
  task automatic t_power_loss();
    cyc(3);
    chk("motor on", 32'h1, motor_on);
    drv.main_power_on <= 1'b0;
    cyc(60);
    drv.main_power_on <= 1'b1;
    cyc(3);
    chk("short dropout", 32'h1, motor_on);
    drv.main_power_on <= 1'b0;
    cyc(140);
    chk("long dropout", 32'h0, motor_on);
    drv.main_power_on <= 1'b1;
    cyc(4);
    chk("power back", 32'h1, motor_on);
    drv.undervolt_alarm <= 1'b1;
    cyc(3);
    chk("undervolt", 32'h0, motor_on);
    drv.undervolt_alarm <= 1'b0;
    drv.control_power_ok <= 1'b0;
    cyc(3);
    chk("control loss", 32'h0, motor_on);
    drv.control_power_ok <= 1'b1;
  endtask : t_power_loss
  task automatic t_irq();
    rchk("irq events", OFS_IRQ_ST, 32'hF);
    cyc(3);
    chk("irq masked", 32'h0, irq);
    wr(OFS_IRQ_ST, 32'hF);
    rchk("irq cleared", OFS_IRQ_ST, 32'h0);
    wr(OFS_IRQ_MASK, 32'hF);
    drv.motor_speed <= 16'sh0100;
    cyc(4);
    chk("irq raised", 32'h1, irq);
    wr(OFS_IRQ_ST, 32'h1);
    cyc(3);
    chk("irq after clear", 32'h0, irq);
  endtask : t_irq
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    drv.main_power_on = 1'b1;
    drv.control_power_ok = 1'b1;
    cyc(20);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset_and_regs();
    t_running();
    t_ready();
    t_warn_alloc();
    t_codes();
    t_power_loss();
    t_irq();
    report_and_stop();
  end
endmodule : tb_top
